// [bench/host_model.sv]
/*
  Host processor model: drives the parallel bus in either style.
  Assumes the caller passes the latched style; one access at a time.
*/
`timescale 1ns/10ps
module host_model (
  input wire logic clk,
  input wire logic style,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [2:0] register_select_lines,
  output logic [7:0] data_in
);
  logic [7:0] drv;
  logic drv_oe;
  logic [7:0] last;
  // floating bus toggles, so a stale byte never passes
  assign data_in = data_oe ? data_out : (drv_oe ? drv : ~last);
  always @(posedge clk) last <= data_in;
  initial begin
    {chip_select_n, read_strobe_n, write_strobe_n} = 3'h7;
    {register_select_lines, drv, drv_oe, last} = '0;
  end
  // ==========================================
  // one bus access
  task automatic xfer(input logic wr, input logic [2:0] s, input logic [7:0] d,
                      input logic cs, output logic [7:0] rd);
    @(posedge clk);
    #2;
    register_select_lines = s;
    drv = d;
    drv_oe = wr;
    chip_select_n = !cs;
    write_strobe_n = !wr;
    read_strobe_n = style ? wr : 1'($urandom);
    repeat (6) @(posedge clk);
    #2;
    // byte taken just before the strobe lets go, off the clock edge
    rd = data_in;
    {chip_select_n, read_strobe_n, write_strobe_n} = 3'h7;
    // data held past release: the write lands from synced copies
    repeat (3) @(posedge clk);
    #2 drv_oe = 1'b0;
    repeat (6) @(posedge clk);
    // hand back off the edge so the caller never races the flops
    #2;
  endtask : xfer
endmodule : host_model

// [bench/host_port_checker.sv]
/*
  Port-level assertions for host_bus_port.
  Assumes a single clk domain and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module host_port_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic attention_req,
  input wire logic data_oe,
  input wire logic attention_out,
  input wire logic attention_oe,
  input wire logic strobe_pair_style
);
  // ==========================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  rd_cs_a: assert property ($rose(data_oe) |-> !$past(chip_select_n, 3))
    else $error("data driven without chip select");
  rd_start_a: assert property (strobe_pair_style && $fell(read_strobe_n) && !chip_select_n
    |-> ##[1:4] data_oe) else $error("read strobe gave no data");
  rw_dir_a: assert property (!strobe_pair_style && $rose(data_oe)
    |-> $past(write_strobe_n, 3)) else $error("select style read without read direction");
  rd_hold_a: assert property ($fell(data_oe) |-> $past(chip_select_n, 3)
    || (strobe_pair_style && $past(read_strobe_n, 3))) else $error("data dropped early");
  oe_read_a: assert property (data_oe |-> $past(write_strobe_n, 3))
    else $error("data driven during write");
  attn_level_a: assert property (strobe_pair_style && $past(strobe_pair_style)
    |-> attention_out == $past(attention_req)) else $error("attention level wrong");
  od_low_a: assert property (!strobe_pair_style && attention_oe |-> !attention_out)
    else $error("open drain drives high");
  od_req_a: assert property (!strobe_pair_style && $rose(attention_oe)
    |-> $past(attention_req)) else $error("open drain pulled without request");
endmodule : host_port_checker

// [bench/tb.sv]
/*
  Self-checking bench for host_bus_port, both bus styles.
  Assumes host_model drives the bus and the checker is bound below.
*/
`timescale 1ns/10ps
module tb;
  logic clk, reset, style_strap, duplex_strap, attention_req, data_oe;
  logic chip_select_n, read_strobe_n, write_strobe_n;
  logic attention_out, attention_oe, half_duplex, strobe_pair_style;
  logic [2:0] register_select_lines;
  logic [7:0] status_in, data_in, data_out, got;
  logic [7:0] exp_reg [8];
  int error_cnt, check_count;
  host_bus_port u_host_bus_port (.clk, .reset, .style_strap, .duplex_strap,
    .chip_select_n, .read_strobe_n, .write_strobe_n, .register_select_lines, .data_in,
    .status_in, .attention_req, .data_out, .data_oe, .attention_out, .attention_oe,
    .half_duplex, .strobe_pair_style);
  host_model u_host_model (.clk, .style(strobe_pair_style), .data_out, .data_oe,
    .chip_select_n, .read_strobe_n, .write_strobe_n, .register_select_lines, .data_in);
  // ==========================================
  // tasks
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", what, exp, seen);
    end
  endtask : check
  task automatic check_bit(input string what, input logic exp, input logic seen);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %b got %b", what, exp, seen);
    end
  endtask : check_bit
  task automatic wr(input logic [2:0] s, input logic [7:0] d, input logic cs = 1);
    u_host_model.xfer(1, s, d, cs, got);
    if (cs && s != 3'h5) exp_reg[s] = d;
  endtask : wr
  task automatic rd(input logic [2:0] s);
    u_host_model.xfer(0, s, 8'h00, 1, got);
    check("read byte", s == 3'h5 ? status_in : exp_reg[s], got);
  endtask : rd
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // ==========================================
  // stimulus
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
  initial begin
    {reset, style_strap, duplex_strap, attention_req} = 4'hE;
    status_in = 8'h00;
    void'($urandom(78));
    for (int m = 0; m < 2; m++) begin
      reset = 1;
      style_strap = (m == 0);
      duplex_strap = (m == 0);
      attention_req = 0;
      repeat (20) @(posedge clk);
      #2 reset = 0;
      foreach (exp_reg[i]) exp_reg[i] = 8'h00;
      repeat (6) @(posedge clk);
      #2;
      check_bit("style", m == 0, strobe_pair_style);
      check_bit("duplex", m == 0, half_duplex);
      status_in = 8'($urandom);
      for (int i = 0; i < 8; i++) wr(3'(i), 8'($urandom));
      wr(3'h1, 8'($urandom), 0);
      for (int i = 0; i < 8; i++) rd(3'(i));
      // select bit alone must leave the strapped duplex in force
      wr(3'h3, 8'h08);
      check_bit("no override", m == 0, half_duplex);
      wr(3'h3, 8'h10);
      check_bit("override", 1'b0, half_duplex);
      wr(3'h3, 8'h18);
      check_bit("override", 1'b1, half_duplex);
      attention_req = 1'b1;
      wr(3'h4, 8'h08);
      check_bit("attn oe", m == 0, attention_oe);
      check_bit("attn out", m == 0, attention_out);
      wr(3'h4, 8'h00);
      check_bit("attn oe", m == 1, attention_oe);
      $display("test style %0d done", m);
    end
    wrap_up();
  end
endmodule : tb
bind host_bus_port host_port_checker u_host_port_checker (.clk, .reset, .chip_select_n,
  .read_strobe_n, .write_strobe_n, .attention_req, .data_oe, .attention_out,
  .attention_oe, .strobe_pair_style);

// [rtl/host_bus_port.sv]
/*
  Dual style host bus port: seven byte registers and a status byte reached over a parallel
  bus in strobe-pair or read/write-select style, attention output, duplex
  strap capture with register override.
  Assumes pins are asynchronous to clk (40 MHz) and strobes last several
  clocks; reset is already in the polarity this port expects (active high).
*/
`timescale 1ns/10ps
`include "host_port_defines.svh"
// =====================================================================
module host_bus_port (
  input wire logic clk,
  input wire logic reset,
  input wire logic style_strap,
  input wire logic duplex_strap,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [2:0] register_select_lines,
  input wire logic [7:0] data_in,
  input wire logic [7:0] status_in,
  input wire logic attention_req,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic attention_out,
  output logic attention_oe,
  output logic half_duplex,
  output logic strobe_pair_style
);
  import host_port_pkg::*;

  // =====================================================================
  // pin synchronisers
  host_bus_t bus_async;
  host_bus_t bus_s;
  logic [1:0] strap_s;

  assign bus_async = '{cs_n: chip_select_n, rd_n: read_strobe_n, wr_n: write_strobe_n,
                       sel: register_select_lines, data: data_in};

  pin_sync #(.WIDTH(14), .INIT(14'h3F00)) u_bus_sync (
    .clk(clk),
    .reset(reset),
    .async_in(bus_async),
    .sync_out(bus_s)
  );

  pin_sync #(.WIDTH(2), .INIT(2'h0)) u_strap_sync (
    .clk(clk),
    .reset(reset),
    .async_in({style_strap, duplex_strap}),
    .sync_out(strap_s)
  );

  // =====================================================================
  // strap capture
  // straps are caught by a clocked process after release, never in reset
  logic strap_done_ff;
  logic style_ff;
  logic duplex_strap_ff;
  logic [1:0] strap_wait_ff;
  logic nxt_strap_done;
  logic nxt_style;
  logic nxt_duplex_strap;
  logic [1:0] nxt_strap_wait;

  always_comb begin
    nxt_strap_done = strap_done_ff;
    nxt_style = style_ff;
    nxt_duplex_strap = duplex_strap_ff;
    nxt_strap_wait = strap_wait_ff;
    if (!strap_done_ff) begin
      // wait for the synchroniser to fill with real pin values
      if (strap_wait_ff == `STRAP_SETTLE) begin
        nxt_strap_done = 1'b1;
        nxt_style = strap_s[1];
        nxt_duplex_strap = strap_s[0];
      end else begin
        nxt_strap_wait = strap_wait_ff + 2'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      strap_done_ff <= 1'b0;
      style_ff <= 1'b1;
      duplex_strap_ff <= 1'b0;
      strap_wait_ff <= 2'h0;
    end else begin
      strap_done_ff <= nxt_strap_done;
      style_ff <= nxt_style;
      duplex_strap_ff <= nxt_duplex_strap;
      strap_wait_ff <= nxt_strap_wait;
    end
  end

  // =====================================================================
  // access decoding
  // in select style the read strobe pin is never looked at
  function automatic logic rd_active(input host_bus_t b, input logic style);
    if (b.cs_n) begin
      rd_active = 1'b0;
    end else if (style) begin
      rd_active = !b.rd_n;
    end else begin
      rd_active = b.wr_n;
    end
  endfunction : rd_active

  function automatic logic wr_active(input host_bus_t b, input logic style);
    if (b.cs_n) begin
      wr_active = 1'b0;
    end else if (style) begin
      wr_active = !b.wr_n;
    end else begin
      wr_active = !b.wr_n;
    end
  endfunction : wr_active

  // =====================================================================
  // register file and bus state machine
  access_state_t state_ff;
  access_state_t nxt_state;
  logic [7:0] regs_ff [`NUM_REGS];
  logic [7:0] nxt_regs [`NUM_REGS];
  logic [2:0] wsel_ff;
  logic [2:0] nxt_wsel;
  logic [7:0] wdata_ff;
  logic [7:0] nxt_wdata;
  logic [7:0] dout_ff;
  logic [7:0] nxt_dout;
  logic doe_ff;
  logic nxt_doe;
  logic rd_now;
  logic wr_now;
  logic [7:0] rd_byte;

  assign rd_now = strap_done_ff && rd_active(bus_s, style_ff);
  assign wr_now = strap_done_ff && wr_active(bus_s, style_ff);

  always_comb begin
    if (bus_s.sel == `SEL_STATUS) begin
      rd_byte = status_in;
    end else begin
      rd_byte = regs_ff[bus_s.sel];
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_regs = regs_ff;
    nxt_wsel = wsel_ff;
    nxt_wdata = wdata_ff;
    nxt_dout = dout_ff;
    nxt_doe = 1'b0;
    case (state_ff)
      access_idle: begin
        if (rd_now) begin
          nxt_state = access_read;
          nxt_dout = rd_byte;
          nxt_doe = 1'b1;
        end else if (wr_now) begin
          nxt_state = access_write;
          nxt_wsel = bus_s.sel;
          nxt_wdata = bus_s.data;
        end
      end
      access_read: begin
        // byte stays frozen until the strobe or chip select lets go
        if (rd_now) begin
          nxt_doe = 1'b1;
        end else begin
          nxt_state = access_idle;
        end
      end
      access_write: begin
        if (wr_now) begin
          // track data right up to the trailing edge
          nxt_wsel = bus_s.sel;
          nxt_wdata = bus_s.data;
        end else begin
          nxt_state = access_idle;
          if (wsel_ff != `SEL_STATUS) begin
            nxt_regs[wsel_ff] = wdata_ff;
          end
        end
      end
      default: begin
        nxt_state = access_idle;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= access_idle;
      for (int i = 0; i < `NUM_REGS; i++) begin
        regs_ff[i] <= `REG_RESET;
      end
      wsel_ff <= 3'h0;
      wdata_ff <= 8'h00;
      dout_ff <= 8'h00;
      doe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      regs_ff <= nxt_regs;
      wsel_ff <= nxt_wsel;
      wdata_ff <= nxt_wdata;
      dout_ff <= nxt_dout;
      doe_ff <= nxt_doe;
    end
  end

  // =====================================================================
  // attention pin and mode outputs
  attn_pin_t attn_ff;
  attn_pin_t nxt_attn;
  logic half_ff;
  logic nxt_half;
  logic [7:0] line_ctrl;
  logic [7:0] feature;

  assign line_ctrl = regs_ff[`SEL_LINE_CTRL];
  assign feature = regs_ff[`SEL_FEATURE];

  always_comb begin
    if (style_ff) begin
      nxt_attn.out = attention_req;
      nxt_attn.oe = line_ctrl[`ATTN_EN_BIT];
    end else begin
      // open drain: only ever pulls low, and only when enabled bit is 0
      nxt_attn.out = 1'b0;
      nxt_attn.oe = attention_req && !line_ctrl[`ATTN_EN_BIT];
    end
    if (feature[`DUPLEX_OVR_BIT]) begin
      nxt_half = feature[`DUPLEX_SEL_BIT];
    end else begin
      nxt_half = duplex_strap_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      attn_ff <= '{out: 1'b0, oe: 1'b0};
      half_ff <= 1'b0;
    end else begin
      attn_ff <= nxt_attn;
      half_ff <= nxt_half;
    end
  end

  assign data_out = dout_ff;
  assign data_oe = doe_ff;
  assign attention_out = attn_ff.out;
  assign attention_oe = attn_ff.oe;
  assign half_duplex = half_ff;
  assign strobe_pair_style = style_ff;

endmodule : host_bus_port

// [rtl/host_port_defines.svh]
/*
  Constants for the dual style host bus port: register select values,
  control bit positions and reset values.
  Assumes nothing; definitions only.
*/
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH

`define SEL_SCRATCH0 3'h0
`define SEL_SCRATCH1 3'h1
`define SEL_SCRATCH2 3'h2
`define SEL_FEATURE 3'h3
`define SEL_LINE_CTRL 3'h4
`define SEL_STATUS 3'h5
`define SEL_SCRATCH6 3'h6
`define SEL_SCRATCH7 3'h7
`define ATTN_EN_BIT 3
`define DUPLEX_SEL_BIT 3
`define DUPLEX_OVR_BIT 4
`define REG_RESET 8'h00
`define NUM_REGS 8
`define STRAP_SETTLE 2'h2

`endif

// [rtl/host_port_pkg.sv]
/*
  Types for the dual style host bus port.
  Assumes host_port_defines.svh is on the include path.
*/
package host_port_pkg;

  typedef enum logic [1:0] {
    access_idle,
    access_read,
    access_write
  } access_state_t;

  // pins of the host bus after synchronisation
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [2:0] sel;
    logic [7:0] data;
  } host_bus_t;

  // attention pin as level plus output enable
  typedef struct packed {
    logic out;
    logic oe;
  } attn_pin_t;

endpackage : host_port_pkg

// [rtl/pin_sync.sv]
/*
  Two flip-flop synchroniser for a packed group of pins.
  Assumes the pins are asynchronous to clk; reset is synchronous.
*/
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  always_comb begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_ff <= INIT;
      sync_ff <= INIT;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;

endmodule : pin_sync
